// ==== include/dmc_pkg.sv ====
package dmc_pkg;
  // ------------------------------------------------------------
  // configuration register indexes
  // ------------------------------------------------------------
  localparam logic [7:0] DMC_IDX_WINDOW_CTRL = 8'h22;
  localparam logic [7:0] DMC_IDX_TAG_LOW = 8'h23;
  localparam logic [7:0] DMC_IDX_TAG_HIGH = 8'h24;
  localparam logic [7:0] DMC_IDX_CACHE_CFG = 8'h2e;
  localparam logic [7:0] DMC_IDX_WRITE_CFG = 8'h2f;
  localparam logic [7:0] DMC_IDX_UNMAPPED_VAL = 8'h00;

  // ------------------------------------------------------------
  // i/o ports: index at 22h (lane 2), data at 23h (lane 3)
  // ------------------------------------------------------------
  localparam logic [29:0] DMC_IO_DWORD = 30'h0000_0008;
  localparam int DMC_LANE_INDEX = 2;
  localparam int DMC_LANE_DATA = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DMC_WINDOW_CTRL_RST = 8'h00;
  localparam logic [7:0] DMC_TAG_LOW_RST = 8'h00;
  localparam logic [1:0] DMC_TAG_HIGH_RST = 2'h0;
  localparam logic [7:0] DMC_CACHE_CFG_RST = 8'h00;
  localparam logic [7:0] DMC_WRITE_CFG_RST = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DMC_WIN_RAM_SEL_BIT = 0;
  localparam int DMC_WIN_TAG_SEL_BIT = 1;
  localparam int DMC_WIN_ONLY_BIT = 2;
  localparam int DMC_WIN_BASE_LSB = 3;
  localparam int DMC_CFG_ENABLE_BIT = 0;
  localparam int DMC_CFG_READ_HIT_BIT = 1;
  localparam int DMC_CFG_SIZE_LSB = 2;
  localparam int DMC_CFG_WIDTH_LSB = 4;
  localparam int DMC_WCFG_NOPOST_BIT = 1;
  localparam int DMC_WCFG_XWAIT_BIT = 2;

  // ------------------------------------------------------------
  // limits and encodings
  // ------------------------------------------------------------
  localparam logic [5:0] DMC_MAX_ADDR_BITS = 6'h1b;
  localparam logic [5:0] DMC_INDEX_TOP_BASE = 6'h0f;
  localparam logic [5:0] DMC_TAG_WIDTH_BASE = 6'h08;

  typedef enum logic [1:0] {
    DMC_SZ_32K,
    DMC_SZ_64K,
    DMC_SZ_128K,
    DMC_SZ_256K
  } dmc_size_t;
endpackage

// ==== design/dmc_cache_ctrl.sv ====
module dmc_cache_ctrl
  import dmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cpu_ads_n_in,
  input wire logic [31:2] cpu_addr_in,
  input wire logic [3:0] cpu_be_n_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_mio_in,
  input wire logic [31:0] cpu_wdata_in,
  output logic cpu_ready_n_out,
  output logic [31:0] cpu_rdata_out,
  output logic cpu_rdata_oe_n_out,
  output logic [15:0] tag_index_out,
  input wire logic [9:0] tag_data_in,
  output logic [9:0] tag_data_out,
  output logic tag_data_oe_n_out,
  output logic tag_we_n_out,
  output logic [15:0] cache_index_out,
  output logic cache_oe_n_out,
  output logic cache_we_n_out,
  output logic dram_start_out,
  output logic dram_we_out,
  output logic [31:2] dram_addr_out,
  output logic [31:0] dram_wdata_out,
  output logic [3:0] dram_be_n_out,
  input wire logic dram_done_in,
  output logic dram_cas_off_out
);

  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOK,
    ST_WAIT,
    ST_MISS,
    ST_WDONE,
    ST_XWAIT
  } dmc_state_t;

  dmc_state_t state_r;
  logic [31:2] addr_r;
  logic [3:0] be_n_r;
  logic wr_r;
  logic mio_r;
  logic dram_busy_r;
  logic [7:0] index_r;
  logic index_valid_r;
  logic [7:0] win_ctrl_r;
  logic [7:0] tag_low_r;
  logic [1:0] tag_high_r;
  logic [7:0] cache_cfg_r;
  logic [7:0] write_cfg_r;

  // ------------------------------------------------------------
  // tag mapping helpers
  // ------------------------------------------------------------
  // expected tag built from the address for the selected size
  function automatic logic [9:0] tag_map(input logic [31:2] a,
                                         input dmc_size_t sz);
    logic [9:0] t;
    t = 10'h000;
    t[8:2] = a[24:18];
    unique case (sz)
      DMC_SZ_32K: begin
        t[0] = a[16];
        t[1] = a[17];
        t[9] = a[15];
      end
      DMC_SZ_64K: begin
        t[0] = a[16];
        t[1] = a[17];
        t[9] = a[25];
      end
      DMC_SZ_128K: begin
        t[0] = a[26];
        t[1] = a[17];
        t[9] = a[25];
      end
      DMC_SZ_256K: begin
        t[0] = a[26];
        t[1] = a[27];
        t[9] = a[25];
      end
    endcase
    return t;
  endfunction

  // tag bits actually wired to the sram for each size and width
  function automatic logic [9:0] tag_mask(input dmc_size_t sz,
                                          input logic [1:0] w);
    logic [9:0] m;
    m = 10'h3ff;
    if (w == 2'h0) begin
      unique case (sz)
        DMC_SZ_32K: m = 10'h27f;
        DMC_SZ_64K: m = 10'h0ff;
        DMC_SZ_128K: m = 10'h1fe;
        DMC_SZ_256K: m = 10'h3fc;
      endcase
    end else if (w == 2'h1) begin
      unique case (sz)
        DMC_SZ_32K: m = 10'h2ff;
        DMC_SZ_64K: m = 10'h1ff;
        DMC_SZ_128K: m = 10'h3fe;
        DMC_SZ_256K: m = 10'h3fd;
      endcase
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // decode of the current cycle
  // ------------------------------------------------------------
  dmc_size_t size_sel;
  logic [1:0] width_sel;
  logic [5:0] limit_bit;
  logic [9:0] exp_tag;
  logic tag_match;
  logic addr_ok;
  logic in_window;
  logic [4:0] win_ignore;
  logic cacheable;
  logic read_hit;
  logic fill_ok;
  logic ram_test;
  logic tag_test;
  logic look;
  logic io_cyc;
  logic io_is_ours;
  logic io_idx_wr;
  logic io_data_wr;
  logic io_data_rd;
  logic tag_latch;
  logic [7:0] sel_val;

  // tag compare, cacheable limit and window decode
  always_comb begin
    size_sel = dmc_size_t'(cache_cfg_r[DMC_CFG_SIZE_LSB +: 2]);
    width_sel = cache_cfg_r[DMC_CFG_WIDTH_LSB +: 2];
    if (width_sel == 2'h3) begin
      width_sel = 2'h2; // unused code behaves as 10 bits
    end
    // index tops at a14+size; tag bits sit above it
    limit_bit = DMC_INDEX_TOP_BASE + 6'(size_sel) + DMC_TAG_WIDTH_BASE
                + 6'(width_sel);
    if (limit_bit > DMC_MAX_ADDR_BITS) begin
      limit_bit = DMC_MAX_ADDR_BITS;
    end
    addr_ok = (({addr_r, 2'b00} >> limit_bit) == 32'h0);
    exp_tag = tag_map(addr_r, size_sel);
    tag_match = (((tag_data_in ^ exp_tag) &
                  tag_mask(size_sel, width_sel)) == 10'h000);
    unique case (size_sel)
      DMC_SZ_32K: win_ignore = 5'h00;
      DMC_SZ_64K: win_ignore = 5'h01;
      DMC_SZ_128K: win_ignore = 5'h03;
      DMC_SZ_256K: win_ignore = 5'h07;
    endcase
    // window sits below 1 mbyte at base a19..a15
    in_window = mio_r && (addr_r[31:20] == 12'h000) &&
                (((addr_r[19:15] ^ win_ctrl_r[7:DMC_WIN_BASE_LSB]) &
                  ~win_ignore) == 5'h00);
    cacheable = addr_ok && (!win_ctrl_r[DMC_WIN_ONLY_BIT] ||
                            in_window);
    fill_ok = cache_cfg_r[DMC_CFG_ENABLE_BIT] && cacheable;
    read_hit = fill_ok && cache_cfg_r[DMC_CFG_READ_HIT_BIT] &&
               tag_match;
    ram_test = in_window && win_ctrl_r[DMC_WIN_RAM_SEL_BIT];
    tag_test = in_window && win_ctrl_r[DMC_WIN_TAG_SEL_BIT] &&
               !ram_test;
  end

  // i/o strobes for the index and data ports
  always_comb begin
    look = (state_r == ST_LOOK);
    io_cyc = look && !mio_r;
    io_is_ours = (addr_r == DMC_IO_DWORD);
    io_idx_wr = io_cyc && io_is_ours && wr_r &&
                !be_n_r[DMC_LANE_INDEX];
    io_data_wr = io_cyc && io_is_ours && wr_r &&
                 !be_n_r[DMC_LANE_DATA] && index_valid_r;
    io_data_rd = io_cyc && io_is_ours && !wr_r &&
                 !be_n_r[DMC_LANE_DATA] && index_valid_r;
    tag_latch = look && mio_r && tag_test && !wr_r;
    unique case (index_r)
      DMC_IDX_WINDOW_CTRL: sel_val = win_ctrl_r;
      DMC_IDX_TAG_LOW: sel_val = tag_low_r;
      DMC_IDX_TAG_HIGH: sel_val = {6'h00, tag_high_r};
      DMC_IDX_CACHE_CFG: sel_val = cache_cfg_r;
      DMC_IDX_WRITE_CFG: sel_val = write_cfg_r;
      default: sel_val = DMC_IDX_UNMAPPED_VAL;
    endcase
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // index must be rewritten before every data access
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      index_r <= 8'h00;
      index_valid_r <= 1'b0;
    end else if (io_idx_wr) begin
      index_r <= cpu_wdata_in[23:16];
      index_valid_r <= 1'b1;
    end else if (io_data_wr || io_data_rd) begin
      index_valid_r <= 1'b0;
    end
  end

  // indexed registers; tag test regs also latch the sram
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      win_ctrl_r <= DMC_WINDOW_CTRL_RST;
      tag_low_r <= DMC_TAG_LOW_RST;
      tag_high_r <= DMC_TAG_HIGH_RST;
      cache_cfg_r <= DMC_CACHE_CFG_RST;
      write_cfg_r <= DMC_WRITE_CFG_RST;
    end else if (tag_latch) begin
      tag_low_r <= tag_data_in[7:0];
      tag_high_r <= tag_data_in[9:8];
    end else if (io_data_wr) begin
      unique case (index_r)
        DMC_IDX_WINDOW_CTRL: win_ctrl_r <= cpu_wdata_in[31:24];
        DMC_IDX_TAG_LOW: tag_low_r <= cpu_wdata_in[31:24];
        DMC_IDX_TAG_HIGH: tag_high_r <= cpu_wdata_in[25:24];
        DMC_IDX_CACHE_CFG: cache_cfg_r <= cpu_wdata_in[31:24];
        DMC_IDX_WRITE_CFG: write_cfg_r <= cpu_wdata_in[31:24];
        default: ;
      endcase
    end
  end

  // read data for the i/o ports, timed with ready
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_rdata_out <= 32'h0000_0000;
      cpu_rdata_oe_n_out <= 1'b1;
    end else if (io_cyc && io_is_ours && !wr_r) begin
      cpu_rdata_out <= {(io_data_rd ? sel_val : 8'h00), index_r,
                        16'h0000};
      cpu_rdata_oe_n_out <= 1'b0;
    end else begin
      cpu_rdata_oe_n_out <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // dram busy tracking
  // ------------------------------------------------------------
  // one posted write at most; a new start only when idle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dram_busy_r <= 1'b0;
    end else if (dram_start_out) begin
      dram_busy_r <= 1'b1;
    end else if (dram_done_in) begin
      dram_busy_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // cycle control
  // ------------------------------------------------------------
  // strobes default inactive; each is a one-cycle pulse
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      addr_r <= 30'h0000_0000;
      be_n_r <= 4'hf;
      wr_r <= 1'b0;
      mio_r <= 1'b0;
      cpu_ready_n_out <= 1'b1;
      tag_index_out <= 16'h0000;
      cache_index_out <= 16'h0000;
      tag_data_out <= 10'h000;
      tag_data_oe_n_out <= 1'b1;
      tag_we_n_out <= 1'b1;
      cache_oe_n_out <= 1'b1;
      cache_we_n_out <= 1'b1;
      dram_start_out <= 1'b0;
      dram_we_out <= 1'b0;
      dram_addr_out <= 30'h0000_0000;
      dram_wdata_out <= 32'h0000_0000;
      dram_be_n_out <= 4'hf;
      dram_cas_off_out <= 1'b0;
    end else begin
      cpu_ready_n_out <= 1'b1;
      tag_we_n_out <= 1'b1;
      tag_data_oe_n_out <= 1'b1;
      cache_we_n_out <= 1'b1;
      dram_start_out <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          cache_oe_n_out <= 1'b1;
          dram_cas_off_out <= 1'b0;
          if (!cpu_ads_n_in) begin
            addr_r <= cpu_addr_in; // all 30 lines kept
            be_n_r <= cpu_be_n_in;
            wr_r <= cpu_wr_in;
            mio_r <= cpu_mio_in;
            // word index: every fourth byte is a new entry
            tag_index_out <= cpu_addr_in[17:2];
            cache_index_out <= cpu_addr_in[17:2];
            // sram read starts early so a hit needs no waits
            cache_oe_n_out <= !(cpu_mio_in && !cpu_wr_in);
            state_r <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (!mio_r) begin
            cpu_ready_n_out <= 1'b0;
            state_r <= ST_IDLE;
          end else if (ram_test) begin
            // window served by data ram, dram kept quiet
            dram_cas_off_out <= 1'b1;
            cache_we_n_out <= !wr_r;
            cpu_ready_n_out <= 1'b0;
            state_r <= ST_IDLE;
          end else if (tag_test) begin
            if (wr_r) begin
              tag_data_out <= {tag_high_r, tag_low_r};
              tag_data_oe_n_out <= 1'b0;
              tag_we_n_out <= 1'b0;
            end
            cpu_ready_n_out <= 1'b0;
            state_r <= ST_IDLE;
          end else if (!wr_r && read_hit) begin
            cpu_ready_n_out <= 1'b0;
            state_r <= ST_IDLE;
          end else if (dram_busy_r) begin
            cache_oe_n_out <= 1'b1;
            state_r <= ST_WAIT;
          end else begin
            // miss or write: dram cycle starts now
            dram_start_out <= 1'b1;
            dram_we_out <= wr_r;
            dram_addr_out <= addr_r;
            dram_be_n_out <= be_n_r;
            cache_oe_n_out <= 1'b1;
            if (!wr_r) begin
              state_r <= ST_MISS;
            end else begin
              dram_wdata_out <= cpu_wdata_in;
              // hit updates sram alongside dram; miss does not
              cache_we_n_out <= !(fill_ok && tag_match);
              if (write_cfg_r[DMC_WCFG_NOPOST_BIT]) begin
                state_r <= ST_WDONE;
              end else if (write_cfg_r[DMC_WCFG_XWAIT_BIT]) begin
                state_r <= ST_XWAIT;
              end else begin
                cpu_ready_n_out <= 1'b0;
                state_r <= ST_IDLE;
              end
            end
          end
        end
        ST_WAIT: begin
          // tag index is held, so the lookup is simply redone
          if (!dram_busy_r) begin
            cache_oe_n_out <= wr_r;
            state_r <= ST_LOOK;
          end
        end
        ST_MISS: begin
          if (dram_done_in) begin
            // dram data lands in cpu and cache together
            cache_we_n_out <= !fill_ok;
            tag_we_n_out <= !fill_ok;
            tag_data_oe_n_out <= !fill_ok;
            tag_data_out <= exp_tag;
            cpu_ready_n_out <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        ST_WDONE: begin
          if (dram_done_in) begin
            if (write_cfg_r[DMC_WCFG_XWAIT_BIT]) begin
              state_r <= ST_XWAIT;
            end else begin
              cpu_ready_n_out <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_XWAIT: begin
          cpu_ready_n_out <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== sim/dmc_far_model.sv ====
module dmc_far_model (
  input wire logic clk_in,
  input wire logic [3:0] dly_in,
  input wire logic [15:0] tag_index_in,
  input wire logic [9:0] tag_data_in,
  input wire logic tag_we_n_in,
  output logic [9:0] tag_data_out,
  input wire logic dram_start_in,
  output logic dram_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] tag_mem [0:65535];
  logic [3:0] cnt = 4'h0;
  // ------------------------------------------------------------
  // tag sram
  // ------------------------------------------------------------
  // blank entries read all ones so a cold line matches only an address whose tag bits are all ones
  initial begin
    for (int i = 0; i < 65536; i++) begin
      tag_mem[i] = 10'h3ff;
    end
    dram_done_out = 1'b0;
  end
  // while the controller drives, our read side shows garbage
  assign tag_data_out = tag_we_n_in ? tag_mem[tag_index_in] :
                        ~tag_mem[tag_index_in];
  always @(posedge clk_in) begin
    if (!tag_we_n_in) begin
      tag_mem[tag_index_in] <= tag_data_in;
    end
  end
  // ------------------------------------------------------------
  // dram controller: done pulse dly_in cycles after start
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    dram_done_out <= 1'b0;
    if (dram_start_in) begin
      cnt <= dly_in;
    end else if (cnt > 4'h1) begin
      cnt <= cnt - 4'h1;
    end else if (cnt == 4'h1) begin
      cnt <= 4'h0;
      dram_done_out <= 1'b1;
    end
  end
endmodule

// ==== sim/dmc_cache_ctrl_chk.sv ====
module dmc_cache_ctrl_chk (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cpu_mio_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_ready_n_out,
  input wire logic cpu_rdata_oe_n_out,
  input wire logic tag_data_oe_n_out,
  input wire logic tag_we_n_out,
  input wire logic cache_oe_n_out,
  input wire logic cache_we_n_out,
  input wire logic dram_start_out,
  input wire logic dram_we_out,
  input wire logic dram_done_in,
  input wire logic dram_cas_off_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // dram cycle in flight, rebuilt from the pins only
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_r <= 1'b0;
    end else if (dram_start_out) begin
      busy_r <= 1'b1;
    end else if (dram_done_in) begin
      busy_r <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  ready_one_cycle_a: assert property (
    !cpu_ready_n_out |=> cpu_ready_n_out)
    else $error("ready held longer than one cycle");
  single_outstanding_a: assert property (
    dram_start_out |-> !busy_r)
    else $error("dram started while busy");
  fill_after_done_a: assert property (
    busy_r && dram_done_in && !dram_we_out |=> !cpu_ready_n_out)
    else $error("read miss not ended after dram done");
  hit_no_wait_a: assert property (
    cpu_mio_in && !cpu_wr_in && !cache_oe_n_out &&
    !$past(cache_oe_n_out) |-> !cpu_ready_n_out)
    else $error("read from cache took a wait state");
  write_hit_both_a: assert property (
    !cache_we_n_out && dram_we_out && !dram_cas_off_out |-> dram_start_out)
    else $error("cache write without dram write");
  posted_release_a: assert property (
    dram_start_out && dram_we_out |-> ##[0:1] !cpu_ready_n_out)
    else $error("cpu not released on posted write");
  tag_write_pulse_a: assert property (
    !tag_we_n_out |-> !tag_data_oe_n_out && !cpu_ready_n_out)
    else $error("tag write not driven with ready");
  io_read_data_a: assert property (
    !cpu_rdata_oe_n_out |-> !cpu_ready_n_out && !cpu_mio_in && !cpu_wr_in)
    else $error("read data enabled outside io read");
  window_no_dram_a: assert property (
    dram_cas_off_out |-> !dram_start_out)
    else $error("dram started in data ram window");
endmodule
bind dmc_cache_ctrl dmc_cache_ctrl_chk dmc_cache_ctrl_chk_inst (
  .clk_in, .reset_n_in, .cpu_mio_in, .cpu_wr_in, .cpu_ready_n_out,
  .cpu_rdata_oe_n_out, .tag_data_oe_n_out, .tag_we_n_out, .cache_oe_n_out,
  .cache_we_n_out, .dram_start_out, .dram_we_out, .dram_done_in,
  .dram_cas_off_out);

// ==== sim/dmc_cache_ctrl_tb.sv ====
module dmc_cache_ctrl_tb;
  import dmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, reset_n_in, cpu_ads_n_in, cpu_wr_in, cpu_mio_in, tw, cw;
  logic [31:2] cpu_addr_in, dram_addr_out;
  logic [3:0] cpu_be_n_in, dram_be_n_out, dly;
  logic [31:0] cpu_wdata_in, cpu_rdata_out, dram_wdata_out, rd;
  logic cpu_ready_n_out, cpu_rdata_oe_n_out, tag_data_oe_n_out, tag_we_n_out;
  logic cache_oe_n_out, cache_we_n_out, dram_start_out, dram_we_out;
  logic dram_done_in, dram_cas_off_out;
  logic [15:0] tag_index_out, cache_index_out;
  logic [9:0] tag_data_in, tag_data_out, td;
  int num_errors = 0, total_checks = 0, lat, starts = 0, cycles = 0, s0;
  localparam logic [31:0] A0 = 32'h01a7_cc10;
  dmc_cache_ctrl dmc_cache_ctrl_inst (.clk_in, .reset_n_in, .cpu_ads_n_in,
    .cpu_addr_in, .cpu_be_n_in, .cpu_wr_in, .cpu_mio_in, .cpu_wdata_in,
    .cpu_ready_n_out, .cpu_rdata_out, .cpu_rdata_oe_n_out, .tag_index_out,
    .tag_data_in, .tag_data_out, .tag_data_oe_n_out, .tag_we_n_out,
    .cache_index_out, .cache_oe_n_out, .cache_we_n_out, .dram_start_out,
    .dram_we_out, .dram_addr_out, .dram_wdata_out, .dram_be_n_out,
    .dram_done_in, .dram_cas_off_out);
  dmc_far_model dmc_far_model_inst (.clk_in, .dly_in(dly),
    .tag_index_in(tag_index_out), .tag_data_in(tag_data_out),
    .tag_we_n_in(tag_we_n_out), .tag_data_out(tag_data_in),
    .dram_start_in(dram_start_out), .dram_done_out(dram_done_in));
  // ------------------------------------------------------------
  // clock, write-start counter and hang guard
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (dram_start_out && dram_we_out) begin
      starts <= starts + 1;
    end
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // checks and bus cycles
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  // latency only bounded from below where dram speed decides it
  task automatic chk_slow(input int min);
    total_checks++;
    if (lat <= min) begin
      num_errors++;
      $display("wrong value at %0t: no wait, latency %0d", $time, lat);
    end
  endtask
  // one processor cycle; results sampled at the ready edge
  task automatic cyc(input logic m, w, input logic [31:2] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_in);
    cpu_ads_n_in <= 1'b0;
    cpu_mio_in <= m;
    cpu_wr_in <= w;
    cpu_addr_in <= a;
    cpu_be_n_in <= be;
    cpu_wdata_in <= d;
    @(posedge clk_in);
    cpu_ads_n_in <= 1'b1;
    lat = 1;
    while (cpu_ready_n_out !== 1'b0 && lat < 200) begin
      @(posedge clk_in);
      lat++;
    end
    chk(32'(lat < 200), 32'h1, "ready seen");
    rd = cpu_rdata_out;
    tw = tag_we_n_out;
    td = tag_data_out;
    cw = cache_we_n_out;
    @(negedge clk_in);
  endtask
  task automatic mem(input logic w, input logic [31:0] ba);
    cyc(1'b1, w, ba[31:2], 4'h0, ~ba);
  endtask
  task automatic io_wr(input logic [7:0] idx, dat);
    cyc(1'b0, 1'b1, DMC_IO_DWORD, 4'hb, {8'h00, idx, 16'h0000});
    cyc(1'b0, 1'b1, DMC_IO_DWORD, 4'h7, {dat, 24'h000000});
  endtask
  task automatic io_rd(input logic [7:0] idx, exp);
    cyc(1'b0, 1'b1, DMC_IO_DWORD, 4'hb, {8'h00, idx, 16'h0000});
    cyc(1'b0, 1'b0, DMC_IO_DWORD, 4'h7, 32'h0);
    chk(32'(rd[31:24]), 32'(exp), "register read");
  endtask
  // tag value expected for each cache size
  function automatic logic [9:0] exp_tag(input logic [1:0] s,
                                         input logic [31:0] a);
    case (s)
      2'h0: return {a[15], a[24:18], a[17], a[16]};
      2'h1: return {a[25], a[24:18], a[17], a[16]};
      2'h2: return {a[25], a[24:18], a[17], a[26]};
      default: return {a[25], a[24:18], a[27], a[26]};
    endcase
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    cpu_ads_n_in = 1'b1;
    {cpu_wr_in, cpu_mio_in, cpu_addr_in, cpu_be_n_in, cpu_wdata_in} = '0;
    dly = 4'h1;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    io_rd(DMC_IDX_WINDOW_CTRL, 8'h00);
    io_rd(8'h41, 8'h00);
    io_wr(DMC_IDX_TAG_LOW, 8'h5a);
    io_rd(DMC_IDX_TAG_LOW, 8'h5a);
    cyc(1'b0, 1'b0, DMC_IO_DWORD, 4'h7, 32'h0);
    chk(rd & 32'hff00_0000, 32'h0, "stale data port");
    io_wr(DMC_IDX_TAG_HIGH, 8'h02);
    io_rd(DMC_IDX_TAG_HIGH, 8'h02);
    $display("register test done");
    // every size: miss fills the tag, repeat read_hit_enable
    for (int s = 0; s < 4; s++) begin
      io_wr(DMC_IDX_CACHE_CFG, {4'h2, s[1:0], 2'h3});
      mem(1'b0, A0);
      chk_slow(3);
      chk({20'h0, cw, tw, td}, {22'h0, exp_tag(s[1:0], A0)}, "fill");
      mem(1'b0, A0);
      chk(lat, 3, "hit latency");
    end
    io_wr(DMC_IDX_CACHE_CFG, 8'h2d);
    mem(1'b0, A0);
    chk_slow(3);
    chk(32'(tw), 32'h0, "init fill");
    io_wr(DMC_IDX_CACHE_CFG, 8'h27);
    mem(1'b0, 32'h0401_0000);
    chk(32'(tw), 32'h1, "uncacheable fill");
    $display("read test done");
    dly = 4'h6;
    mem(1'b0, A0);
    s0 = starts;
    mem(1'b1, A0);
    chk(lat, 3, "write release");
    chk(32'(cw), 32'h0, "write hit sram");
    chk({dram_addr_out, 2'b00}, A0, "posted address");
    chk(dram_wdata_out, ~A0, "posted data");
    chk(32'(dram_be_n_out), 32'h0, "posted lanes");
    chk(32'(cache_index_out), 32'(A0[17:2]), "cache index");
    mem(1'b1, A0 ^ 32'h0010_0000);
    chk_slow(3);
    chk({30'h0, tw, cw}, 32'h3, "write miss");
    mem(1'b0, A0);
    chk(lat, 3, "hit under posted write");
    chk(starts - s0, 2, "dram writes");
    io_wr(DMC_IDX_WRITE_CFG, 8'h04);
    mem(1'b1, A0);
    chk(lat, 4, "extra write wait");
    io_wr(DMC_IDX_WRITE_CFG, 8'h00);
    $display("write test done");
    // tag window at 80000h, entry 3 is byte address 8000ch
    io_wr(DMC_IDX_WINDOW_CTRL, 8'h82);
    io_wr(DMC_IDX_TAG_LOW, 8'ha5);
    io_wr(DMC_IDX_TAG_HIGH, 8'h01);
    mem(1'b1, 32'h0008_000c);
    chk(32'(dmc_far_model_inst.tag_mem[3]), 32'h1a5, "tag store");
    io_wr(DMC_IDX_TAG_LOW, 8'h00);
    cyc(1'b1, 1'b0, 30'h0002_0003, 4'hd, 32'h0);
    io_rd(DMC_IDX_TAG_LOW, 8'ha5);
    // data ram window; a15 is not decoded for a 64k cache
    io_wr(DMC_IDX_WINDOW_CTRL, 8'h81);
    s0 = starts;
    mem(1'b1, 32'h0008_8000);
    chk(starts - s0, 0, "window write");
    mem(1'b1, 32'h0009_0000);
    chk(starts - s0, 1, "outside window");
    io_wr(DMC_IDX_WINDOW_CTRL, 8'h85);
    mem(1'b0, A0);
    chk({30'h0, tw, 1'b0}, 32'h2, "only window cacheable");
    io_wr(DMC_IDX_WINDOW_CTRL, 8'h00);
    $display("window test done");
    close_out();
  end
endmodule
